// ===== accel_self_test_timing.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
// Operation
// - Idle register holds a 5-bit idle code in bits 4:0; upper bits unused.
// - Idle phase lasts 312.5 us plus 31.25 us times the idle code.
// - Decimation register holds a 4-bit code in bits 3:0, range 1..4096.
// - Codes 0..12 give 2^code samples; codes 13..15 saturate at 4096.
// - Measurement period equals the sample count times the idle-phase duration.
// - Idle code 0, decimation 0 gives 0.3125 ms; each decimation step up to code 12 halves rate.
// - During self-test, user ODR and power mode are ignored.
// - Axis select written to zero ends self-test and restores user settings.
module accel_self_test_timing
    import accel_self_test_pkg::*;
#(
    parameter int IDLE_BASE_CYCLES = IDLE_BASE_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic selftestActive,
    output logic excitationNegative,
    output logic sampleStrobe,
    output logic periodDone,
    output logic [ODR_W-1:0] effOdrCode,
    output logic [PMODE_W-1:0] effPowerMode,
    output logic [AXIS_W-1:0] activeAxis
);

    // Samples per measurement period for a decimation code
    // Codes above the last power of two saturate at the top count
    function automatic logic [SAMPLE_W-1:0] decSamples(
        input logic [DEC_CODE_W-1:0] code
    );
        logic [SAMPLE_W-1:0] n;
        if (code > DEC_SAT_CODE) begin
            n = DEC_MAX_SAMPLES;
        end else begin
            n = SAMPLE_W'(1) << code;
        end
        return n;
    endfunction

    // Register index from a byte address
    // Offsets are word aligned, so each word sits at four times its index
    function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

    // Local reset copy; only the second flop is read by the logic
    logic resetSync1;
    logic resetN;

    // Reset release through two flops
    // Reset takes hold at once, release waits two edges so that no
    // flop leaves reset on a different edge than its neighbours
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetSync1 <= 1'b0;
            resetN <= 1'b0;
        end else begin
            resetSync1 <= 1'b1;
            resetN <= resetSync1;
        end
    end

    // Register file
    // Three byte registers behind one aligned word each; the upper
    // three bytes of every word read as zero and ignore writes
    // Stored bytes and their next values
    logic [7:0] idleCfg;
    logic [7:0] decCfg;
    logic [7:0] sensorCfg;
    logic [7:0] next_idleCfg;
    logic [7:0] next_decCfg;
    logic [7:0] next_sensorCfg;
    // Bus answer staging
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] statusWord;
    logic setupPhase;
    logic writeDone;
    logic mapped;
    logic [7:0] idx;

    // Fields taken from the stored bytes
    logic [IDLE_CODE_W-1:0] idleCode;
    logic [DEC_CODE_W-1:0] decCode;
    logic [ODR_W-1:0] userOdr;
    logic [PMODE_W-1:0] userPmode;
    logic [AXIS_W-1:0] axisSelect;

    // Field extraction; upper bits of the idle and decimation registers unused
    assign idleCode = idleCfg[IDLE_CODE_LSB +: IDLE_CODE_W];
    assign decCode = decCfg[DEC_CODE_LSB +: DEC_CODE_W];
    assign userOdr = sensorCfg[ODR_LSB +: ODR_W];
    assign userPmode = sensorCfg[PMODE_LSB +: PMODE_W];
    assign axisSelect = sensorCfg[AXIS_LSB +: AXIS_W];

    // Samples finished in the current measurement period
    logic [SAMPLE_W-1:0] sampleCount;

    // Status word shows the block's own state
    // Bit 0 active, bit 1 direction, then the running sample count
    always_comb begin
        statusWord = '0;
        statusWord[STAT_ACTIVE_BIT] = selftestActive;
        statusWord[STAT_NEG_BIT] = excitationNegative;
        statusWord[STAT_CNT_LSB +: SAMPLE_W] = sampleCount;
    end

    assign idx = regIndex(paddr);
    assign setupPhase = psel && !penable;
    assign writeDone = psel && penable && pready && pwrite && !pslverr;

    // Address decode
    // Status is the only read-only entry in the map
    always_comb begin
        case (idx)
            IDX_IDLE_CFG,
            IDX_DEC_CFG,
            IDX_SENSOR_CFG,
            IDX_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // APB answer: ready in the first access cycle, error when unmapped
    // Zero wait states keep the bus simple; read data is captured at the
    // setup edge, so a read sees the value stored before that edge
    always_comb begin
        next_pready = setupPhase;
        next_pslverr = 1'b0;
        next_prdata = '0;
        if (setupPhase) begin
            next_pslverr = !mapped || (pwrite && idx == IDX_STATUS);
            if (!pwrite) begin
                case (idx)
                    IDX_IDLE_CFG: next_prdata = {24'h000000, idleCfg};
                    IDX_DEC_CFG: next_prdata = {24'h000000, decCfg};
                    IDX_SENSOR_CFG: next_prdata = {24'h000000, sensorCfg};
                    IDX_STATUS: next_prdata = statusWord;
                    default: next_prdata = '0;
                endcase
            end
        end
    end

    // Register writes at the completing edge, low byte lane only
    // Writes need the low strobe; other lanes hold no storage
    always_comb begin
        next_idleCfg = idleCfg;
        next_decCfg = decCfg;
        next_sensorCfg = sensorCfg;
        if (writeDone && pstrb[0]) begin
            case (idx)
                IDX_IDLE_CFG: next_idleCfg = pwdata[7:0];
                IDX_DEC_CFG: next_decCfg = pwdata[7:0];
                IDX_SENSOR_CFG: next_sensorCfg = pwdata[7:0];
                default: next_sensorCfg = sensorCfg;
            endcase
        end
    end

    // Register storage, reset to zero
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            idleCfg <= IDLE_CFG_RST;
            decCfg <= DEC_CFG_RST;
            sensorCfg <= SENSOR_CFG_RST;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            idleCfg <= next_idleCfg;
            decCfg <= next_decCfg;
            sensorCfg <= next_sensorCfg;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Self-test sequencer
    // Configuration edits take effect at once, even mid-period; software
    // should stop self-test before changing the timing fields
    self_state_e state;
    self_state_e next_state;
    logic idleTick;
    logic timerRun;
    // Next values of the sequencer outputs
    logic [SAMPLE_W-1:0] next_sampleCount;
    logic next_negative;
    logic next_sampleStrobe;
    logic next_periodDone;
    logic next_active;
    // Effective settings staged for the outputs
    logic [ODR_W-1:0] next_effOdr;
    logic [PMODE_W-1:0] next_effPmode;
    logic [AXIS_W-1:0] next_activeAxis;
    logic [SAMPLE_W-1:0] lastSample;

    // Timer runs only while engaged and an axis is still selected
    assign timerRun = (state == SELF_RUN) && (axisSelect != AXIS_OFF);

    // Idle phase timer: one tick per idle-phase duration
    // Base and step are counted in core clocks
    idle_phase_timer #(
        .BASE_CYCLES(IDLE_BASE_CYCLES)
    ) idleTimer (
        .clock(clock),
        .resetN(resetN),
        .run(timerRun),
        .idleCode(idleCode),
        .tick(idleTick)
    );

    // Last sample index of a period; saturated codes share one count
    assign lastSample = decSamples(decCode) - 1'b1;

    // Run state follows the axis select; counts samples per period
    always_comb begin
        next_state = state;
        next_sampleCount = sampleCount;
        next_negative = excitationNegative;
        next_sampleStrobe = 1'b0;
        next_periodDone = 1'b0;
        case (state)
            SELF_OFF: begin
                next_sampleCount = '0;
                next_negative = 1'b0;
                if (axisSelect != AXIS_OFF) begin
                    next_state = SELF_RUN;
                end
            end
            SELF_RUN: begin
                if (axisSelect == AXIS_OFF) begin
                    next_state = SELF_OFF;
                    next_sampleCount = '0;
                    next_negative = 1'b0;
                end else if (idleTick) begin
                    next_sampleStrobe = 1'b1;
                    if (sampleCount >= lastSample) begin
                        // decSamples(decCode) idle durations make one period
                        next_periodDone = 1'b1;
                        next_sampleCount = '0;
                        next_negative = !excitationNegative;
                    end else begin
                        next_sampleCount = sampleCount + 1'b1;
                    end
                end
            end
            default: next_state = SELF_OFF;
        endcase
    end

    // Effective rate and power mode: user values only outside self-test
    // Registered so that the suspended settings switch on one edge
    always_comb begin
        next_active = (next_state == SELF_RUN);
        if (next_active) begin
            next_effOdr = ODR_SELFTEST;
            next_effPmode = PMODE_SELFTEST;
            next_activeAxis = axisSelect;
        end else begin
            next_effOdr = userOdr;
            next_effPmode = userPmode;
            next_activeAxis = AXIS_OFF;
        end
    end

    // Sequencer registers
    // Direction and counts clear on reset and whenever self-test stops
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            state <= SELF_OFF;
            sampleCount <= '0;
            excitationNegative <= 1'b0;
            sampleStrobe <= 1'b0;
            periodDone <= 1'b0;
            selftestActive <= 1'b0;
            effOdrCode <= '0;
            effPowerMode <= '0;
            activeAxis <= AXIS_OFF;
        end else begin
            state <= next_state;
            sampleCount <= next_sampleCount;
            excitationNegative <= next_negative;
            sampleStrobe <= next_sampleStrobe;
            periodDone <= next_periodDone;
            selftestActive <= next_active;
            effOdrCode <= next_effOdr;
            effPowerMode <= next_effPmode;
            activeAxis <= next_activeAxis;
        end
    end

endmodule // accel_self_test_timing

// ===== accel_self_test_pkg.sv
package accel_self_test_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 50;

    // Idle phase timing in nanoseconds
    localparam int IDLE_BASE_NS = 312500;
    localparam int IDLE_STEP_NS = 31250;
    localparam int IDLE_BASE_CYC = IDLE_BASE_NS / CLK_PERIOD_NS;
    localparam int IDLE_STEP_CYC = IDLE_STEP_NS / CLK_PERIOD_NS;

    // Idle counter width, wide enough for base plus 31 steps
    localparam int IDLE_CNT_W = 15;
    localparam logic [IDLE_CNT_W-1:0] IDLE_STEP = IDLE_STEP_CYC[IDLE_CNT_W-1:0];

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IDLE_CFG = 8'h37;
    localparam logic [7:0] IDX_DEC_CFG = 8'h38;
    localparam logic [7:0] IDX_SENSOR_CFG = 8'h3a;
    localparam logic [7:0] IDX_STATUS = 8'h3b;
    localparam int ADDR_W = 10;

    // Reset values
    localparam logic [7:0] IDLE_CFG_RST = 8'h00;
    localparam logic [7:0] DEC_CFG_RST = 8'h00;
    localparam logic [7:0] SENSOR_CFG_RST = 8'h00;

    // Field positions
    localparam int IDLE_CODE_LSB = 0;
    localparam int IDLE_CODE_W = 5;
    localparam int DEC_CODE_LSB = 0;
    localparam int DEC_CODE_W = 4;
    localparam int ODR_LSB = 0;
    localparam int ODR_W = 4;
    localparam int PMODE_LSB = 4;
    localparam int PMODE_W = 2;
    localparam int AXIS_LSB = 6;
    localparam int AXIS_W = 2;

    // Status fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_NEG_BIT = 1;
    localparam int STAT_CNT_LSB = 2;

    // Decimation
    localparam int SAMPLE_W = 13;
    localparam logic [DEC_CODE_W-1:0] DEC_SAT_CODE = 4'hc;
    localparam logic [SAMPLE_W-1:0] DEC_MAX_SAMPLES = 13'h1000;
    localparam logic [AXIS_W-1:0] AXIS_OFF = 2'h0;

    // Rate and power mode held while self-test owns the timing
    localparam logic [PMODE_W-1:0] PMODE_SELFTEST = 2'h0;
    localparam logic [ODR_W-1:0] ODR_SELFTEST = 4'h0;

    typedef enum logic {SELF_OFF, SELF_RUN} self_state_e;

endpackage

// ===== idle_phase_timer.sv
`timescale 1ns/100ps
module idle_phase_timer
    import accel_self_test_pkg::*;
#(
    parameter int BASE_CYCLES = IDLE_BASE_CYC
) (
    input wire logic clock,
    input wire logic resetN,
    input wire logic run,
    input wire logic [IDLE_CODE_W-1:0] idleCode,
    output logic tick
);

    logic [IDLE_CNT_W-1:0] count;
    logic [IDLE_CNT_W-1:0] next_count;
    logic next_tick;
    logic [IDLE_CNT_W-1:0] lastCount;

    // Last count of one idle phase: base plus code steps, minus one
    always_comb begin
        lastCount = BASE_CYCLES[IDLE_CNT_W-1:0]
            + IDLE_CNT_W'(idleCode * IDLE_STEP) - 1'b1;
        next_count = '0;
        next_tick = 1'b0;
        if (run) begin
            if (count >= lastCount) begin
                next_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    // Counter and end-of-phase pulse
    always_ff @(posedge clock or negedge resetN) begin
        if (!resetN) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

endmodule // idle_phase_timer

// ===== accel_self_test_timing_sva.sv
`timescale 1ns/100ps
module accel_self_test_timing_sva
    import accel_self_test_pkg::*;
#(
    parameter int IDLE_BASE_CYCLES = IDLE_BASE_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic selftestActive,
    input wire logic sampleStrobe,
    input wire logic periodDone,
    input wire logic [ODR_W-1:0] effOdrCode,
    input wire logic [PMODE_W-1:0] effPowerMode,
    input wire logic [AXIS_W-1:0] activeAxis
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Bus setup phase and the quiet gap after an idle-phase end
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence strobeGap;
        sampleStrobe ##1 !sampleStrobe [*8];
    endsequence
    AST_PREADY_NEXT: assert property (apbSetup |=> pready)
        else $error("no pready after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ODR_HELD: assert property (selftestActive
        && $past(selftestActive) |-> effOdrCode == ODR_SELFTEST)
        else $error("user rate leaks into self-test");
    AST_PM_HELD: assert property (selftestActive
        && $past(selftestActive) |-> effPowerMode == PMODE_SELFTEST)
        else $error("user power mode leaks into self-test");
    AST_AXIS_OFF: assert property (!selftestActive
        && !$past(selftestActive) |-> activeAxis == AXIS_OFF)
        else $error("axis shown while inactive");
    AST_STROBE_GAP: assert property (sampleStrobe |-> strobeGap)
        else $error("idle phase too short");
    AST_DONE_STROBE: assert property (periodDone |-> sampleStrobe)
        else $error("period end off a sample end");
    AST_STROBE_RUN: assert property (sampleStrobe
        |-> $past(selftestActive))
        else $error("sample end while inactive");
endmodule // accel_self_test_timing_sva

bind accel_self_test_timing accel_self_test_timing_sva
    #(.IDLE_BASE_CYCLES(IDLE_BASE_CYCLES)) sva (.clock, .reset_n, .psel,
    .penable, .pready, .pslverr, .selftestActive, .sampleStrobe, .periodDone,
    .effOdrCode, .effPowerMode, .activeAxis);

// ===== accel_self_test_timing_test.sv
`timescale 1ns/100ps
module accel_self_test_timing_test;
    import accel_self_test_pkg::*;
    localparam int BASE = 10;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, selftestActive, excitationNegative;
    logic sampleStrobe, periodDone, er, dir;
    logic [ODR_W-1:0] effOdrCode;
    logic [PMODE_W-1:0] effPowerMode;
    logic [AXIS_W-1:0] activeAxis;
    int err_count = 0, total_checks = 0;

    accel_self_test_timing #(.IDLE_BASE_CYCLES(BASE)) dut (.clock, .reset_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .selftestActive, .excitationNegative, .sampleStrobe,
        .periodDone, .effOdrCode, .effPowerMode, .activeAxis);

    // Core clock
    initial forever #25 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; answer taken at the edge that completes it
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic test_regs;
        apb(0, IDX_IDLE_CFG, 0);
        check(rd, {24'h0, IDLE_CFG_RST});
        check(er, 0);
        apb(0, IDX_DEC_CFG, 0);
        check(rd, {24'h0, DEC_CFG_RST});
        apb(1, IDX_IDLE_CFG, 32'h0000_00ff);
        apb(0, IDX_IDLE_CFG, 0);
        check(rd, 32'hff);
        pstrb <= 4'he;
        apb(1, IDX_IDLE_CFG, 32'h0);
        pstrb <= 4'hf;
        apb(0, IDX_IDLE_CFG, 0);
        check(rd, 32'hff);
        apb(1, IDX_DEC_CFG, 32'hffff_fff7);
        apb(0, IDX_DEC_CFG, 0);
        check(rd, 32'hf7);
        apb(1, IDX_STATUS, 32'h0);
        check(er, 1);
        apb(0, 8'h39, 0);
        check(rd, 0);
        check(er, 1);
    endtask

    // Stopped: user rate 5, power mode 2 must show
    task automatic check_user;
        apb(1, IDX_SENSOR_CFG, 32'h25);
        repeat (2) @(posedge clock);
        #1;
        check(effOdrCode, 5);
        check(effPowerMode, 2);
        check({selftestActive, excitationNegative, activeAxis}, 0);
        apb(0, IDX_STATUS, 0);
        check(rd, 0);
    endtask

    // Fresh start, count sample ends to first period end, then time one
    task automatic run_case(input logic [7:0] idle, dec, input int n,
                            input bit timed);
        int s;
        int c;
        check_user();
        apb(1, IDX_IDLE_CFG, {24'h0, idle});
        apb(1, IDX_DEC_CFG, {24'h0, dec});
        apb(1, IDX_SENSOR_CFG, 32'h65);
        repeat (2) @(posedge clock);
        #1;
        check({selftestActive, activeAxis}, 3'b101);
        check({effOdrCode, effPowerMode}, 0);
        apb(0, IDX_STATUS, 0);
        check(rd, 32'h1);
        s = 0;
        do begin
            @(posedge clock);
            #1;
            s += sampleStrobe;
        end while (periodDone !== 1'b1);
        check(s, n);
        if (timed) begin
            @(posedge clock);
            #1;
            dir = excitationNegative;
            check(dir, 1);
            c = 1;
            do begin
                @(posedge clock);
                #1;
                c++;
            end while (periodDone !== 1'b1);
            check(c, n * (BASE + 625 * idle));
            @(posedge clock);
            #1;
            check(excitationNegative, !dir);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog against a hung wait
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1;
        repeat (3) @(posedge clock);
        test_regs();
        run_case(0, 0, 1, 1);
        run_case(1, 2, 4, 1);
        run_case(0, 3, 8, 1);
        run_case(0, 13, 4096, 0);
        run_case(0, 15, 4096, 0);
        check_user();
        final_report();
    end
endmodule // accel_self_test_timing_test
